// ===== sac_consts.vh
// Constants for the security alarm and lifecycle controller
`ifndef SAC_CONSTS_VH
`define SAC_CONSTS_VH

// ==========================================================
// Register offsets (byte addresses on APB)
`define SAC_OFF_CAUSE 8'h00
`define SAC_OFF_ISTAT 8'h04
`define SAC_OFF_ICLR 8'h08
`define SAC_OFF_IEN 8'h0c
`define SAC_OFF_ACTION 8'h10
`define SAC_OFF_LCYC 8'h14
`define SAC_OFF_FADDR 8'h18

// ==========================================================
// Field layout and reset values
`define SAC_NSRC 12
`define SAC_NINT 13
`define SAC_VIOL_BIT 12
`define SAC_ACT_SELFTEST 0
`define SAC_ACT_RNG_TOT 1
`define SAC_ACT_RNG_STAT 2
`define SAC_ACT_CLKMON 3
`define SAC_ACTION_RST 4'h7
`define SAC_IEN_RST 13'h0000
`define SAC_LC_KEY 32'ha5c35a3c

// ==========================================================
// Address regions checked by the access policy
`define SAC_MFG_LO 32'h00080000
`define SAC_MFG_HI 32'h00080fff
`define SAC_SFR_LO 32'h40000000
`define SAC_SFR_HI 32'h4000ffff
`define SAC_TST_LO 32'h50000000
`define SAC_TST_HI 32'h50000fff

// ==========================================================
// Timing, in ns, and derived pclk cycle counts
`define SAC_CLK_NS 10
`define SAC_CLK_MIN_HALF_NS 30
`define SAC_CLK_MAX_HALF_NS 2000
`define SAC_RST_MIN_NS 100
`define SAC_CRST_NS 1000
`define SAC_CLK_MIN_CYC \
  ((`SAC_CLK_MIN_HALF_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_CLK_MAX_CYC (`SAC_CLK_MAX_HALF_NS / `SAC_CLK_NS)
`define SAC_RST_MIN_CYC \
  ((`SAC_RST_MIN_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_CRST_CYC \
  ((`SAC_CRST_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)

`endif

// ===== sac_pad_mon.v
// Pad monitor: synchroniser, glitch filter and frequency check
`timescale 1ns/1ps
module sac_pad_mon #(
  parameter CHK_SLOW = 1'b0,
  parameter [7:0] MIN_CYC = 8'h03,
  parameter [7:0] MAX_CYC = 8'hc8
) (
  input wire pclk,
  input wire presetn,
  input wire en,
  input wire pad,
  output reg clean,
  output reg alarm
);

  reg s1;
  reg s2;
  reg s3;
  reg lvl;
  reg [7:0] cnt;
  wire chg;

  // A change counts only once stages two and three agree
  assign chg = (s2 == s3) && (s2 != lvl);

  // ========================================================
  // Synchroniser and agreed level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      lvl <= 1'b0;
    end else begin
      s1 <= pad;
      s2 <= s1;
      s3 <= s2;
      if (chg) begin
        lvl <= s2;
      end
    end
  end

  // ========================================================
  // Time since the last change, saturating; starts at the minimum
  // so a pad already high at reset release is not taken as a glitch
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= MIN_CYC;
    end else if (chg) begin
      cnt <= 8'h00;
    end else if (cnt != 8'hff) begin
      cnt <= cnt + 8'h01;
    end
  end

  // Short pulses never reach the core; they raise an alarm
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clean <= 1'b0;
      alarm <= 1'b0;
    end else begin
      if (!chg && cnt >= MIN_CYC) begin
        clean <= lvl; // [R04]
      end
      alarm <= en & ((chg & (cnt < MIN_CYC)) |
               (CHK_SLOW & (cnt == MAX_CYC))); // [R04]
    end
  end

endmodule

// ===== sac_ctrl.v
// Security alarm, lifecycle and access-policy controller
//
// Overview of operation
// [R01] Every alarm yields reset, exception or error
// [R02] Environmental alarm sets status and forces reset
// [R03] Sensor self-test and RNG failures are alarms
// [R04] Clock and reset pads filtered in hardware
// [R05] Shield or probing alarm resets the chip
// [R06] Application mode is permanent; no return
// [R07] Application mode: manufacturing area read-only
// [R08] Functional test only allowed in test mode
// [R09] Policy violation blocked and raises hard fault
// [R10] Alarm cause survives alarm reset, POR clears
// [R11] Lifecycle from set-only nonvolatile flag
`timescale 1ns/1ps
`include "sac_consts.vh"
module sac_ctrl (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [2:0] pprot,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [4:0] env_alarm,
  input wire selftest_fail,
  input wire rng_total_fail,
  input wire rng_stat_fail,
  input wire shield_alarm,
  input wire probe_alarm,
  input wire ext_clk_pad,
  input wire ext_rst_pad,
  output wire ext_clk_clean,
  output wire ext_rst_clean,
  input wire nv_app_flag,
  output reg nv_app_prog,
  input wire test_req,
  input wire func_test_req,
  output reg test_mode_en,
  output reg func_test_en,
  input wire acc_req,
  input wire acc_wr,
  input wire acc_priv,
  input wire [31:0] acc_addr,
  output reg acc_grant,
  output reg acc_deny,
  output reg chip_rst_req,
  output reg alarm_exc,
  output reg hardfault,
  output reg irq
);

  // Lifecycle states, one-hot
  localparam [2:0] LC_INIT = 3'b001;
  localparam [2:0] LC_TEST = 3'b010;
  localparam [2:0] LC_APP = 3'b100;
  localparam integer CRST_I = `SAC_CRST_CYC;
  localparam integer CLK_MIN_I = `SAC_CLK_MIN_CYC;
  localparam integer CLK_MAX_I = `SAC_CLK_MAX_CYC;
  localparam integer RST_MIN_I = `SAC_RST_MIN_CYC;
  localparam [6:0] CRST_LOAD = CRST_I[6:0];
  localparam [7:0] CLK_MIN = CLK_MIN_I[7:0];
  localparam [7:0] CLK_MAX = CLK_MAX_I[7:0];
  localparam [7:0] RST_MIN = RST_MIN_I[7:0];

  // ========================================================
  // Pin synchronisers for alarm, test and strap inputs
  wire [12:0] pin_raw;
  reg [12:0] pin_s1;
  reg [12:0] pin_s2;
  reg [12:0] pin_s3;
  reg [12:0] pin_f;
  wire [12:0] pin_agree;

  assign pin_raw = {nv_app_flag, func_test_req, test_req, probe_alarm,
                    shield_alarm, rng_stat_fail, rng_total_fail,
                    selftest_fail, env_alarm};
  assign pin_agree = ~(pin_s2 ^ pin_s3);

  // Three stages; a level moves only when stages two and three agree
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1 <= 13'h0000;
      pin_s2 <= 13'h0000;
      pin_s3 <= 13'h0000;
      pin_f <= 13'h0000;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= (pin_s2 & pin_agree) | (pin_f & ~pin_agree);
    end
  end

  // ========================================================
  // Clock and reset pad monitors
  reg [3:0] action;
  wire clk_alm;
  wire rst_alm;

  // Clock pad: too fast or stopped both count as alarms
  sac_pad_mon #(
    .CHK_SLOW(1'b1),
    .MIN_CYC(CLK_MIN),
    .MAX_CYC(CLK_MAX)
  ) u_clk_mon (
    .pclk(pclk),
    .presetn(presetn),
    .en(action[`SAC_ACT_CLKMON]),
    .pad(ext_clk_pad),
    .clean(ext_clk_clean),
    .alarm(clk_alm)
  ); // [R04]

  // Reset pad: pulses shorter than the minimum are glitches
  sac_pad_mon #(
    .CHK_SLOW(1'b0),
    .MIN_CYC(RST_MIN),
    .MAX_CYC(8'hff)
  ) u_rst_mon (
    .pclk(pclk),
    .presetn(presetn),
    .en(1'b1),
    .pad(ext_rst_pad),
    .clean(ext_rst_clean),
    .alarm(rst_alm)
  ); // [R04]

  // ========================================================
  // Alarm sources and their response class
  wire [11:0] src;
  wire [11:0] rst_mask;
  wire [11:0] ev;
  wire rst_trig;
  wire exc_trig;
  reg [11:0] src_q;

  // Bits: 4..0 environment, 5 self-test, 6..7 RNG, 8 shield,
  // 9 probe, 10 clock pad, 11 reset pad
  assign src = {rst_alm, clk_alm, pin_f[9:0]}; // [R03]
  // Environment, shield, probe and pads always reset the chip
  assign rst_mask = {4'hf, action[`SAC_ACT_RNG_STAT],
                     action[`SAC_ACT_RNG_TOT],
                     action[`SAC_ACT_SELFTEST], 5'h1f}; // [R02] [R05]
  assign ev = src & ~src_q;
  assign rst_trig = |(src & rst_mask); // [R01]
  assign exc_trig = |(ev & ~rst_mask); // [R01] [R03]

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_q <= 12'h000;
    end else begin
      src_q <= src;
    end
  end

  // ========================================================
  // Reset cause: presetn is the power-on reset, and the chip
  // reset this block requests does not reach these flops
  reg [11:0] cause;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cause <= 12'h000;
    end else begin
      cause <= cause | src; // [R02] [R10]
    end
  end

  // Chip reset stays asserted while a reset-class alarm persists
  reg [6:0] crst_cnt;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      crst_cnt <= 7'h00;
      chip_rst_req <= 1'b0;
      alarm_exc <= 1'b0;
    end else begin
      if (rst_trig) begin
        crst_cnt <= CRST_LOAD;
      end else if (crst_cnt != 7'h00) begin
        crst_cnt <= crst_cnt - 7'h01;
      end
      chip_rst_req <= rst_trig | (crst_cnt != 7'h00); // [R02] [R05]
      alarm_exc <= exc_trig; // [R01]
    end
  end

  // ========================================================
  // APB decode
  wire setup;
  wire wr_en;
  wire apb_viol;
  reg map_ok;
  reg ro_reg;
  reg [31:0] rd_mux;

  assign setup = psel & ~penable;
  // Writes take effect at the edge that completes the access
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;
  // Unprivileged register writes count as policy violations
  assign apb_viol = setup & pwrite & ~pprot[0]; // [R09]

  reg [2:0] lc_state;
  reg [`SAC_NINT-1:0] ists;
  reg [`SAC_NINT-1:0] ien;
  reg [31:0] fault_addr;

  // Read mux and address map
  always @* begin
    map_ok = 1'b1;
    ro_reg = 1'b0;
    rd_mux = 32'h00000000;
    case (paddr)
      `SAC_OFF_CAUSE: begin
        ro_reg = 1'b1;
        rd_mux = {20'h00000, cause}; // [R10]
      end
      `SAC_OFF_ISTAT: begin
        ro_reg = 1'b1;
        rd_mux = {19'h00000, ists};
      end
      `SAC_OFF_ICLR: begin
        rd_mux = 32'h00000000;
      end
      `SAC_OFF_IEN: begin
        rd_mux = {19'h00000, ien};
      end
      `SAC_OFF_ACTION: begin
        rd_mux = {28'h0000000, action};
      end
      `SAC_OFF_LCYC: begin
        rd_mux = {29'h00000000, test_mode_en, lc_state[2],
                  ~lc_state[0]};
      end
      `SAC_OFF_FADDR: begin
        ro_reg = 1'b1;
        rd_mux = fault_addr;
      end
      default: begin
        map_ok = 1'b0;
      end
    endcase
  end

  // Zero-wait answer: data and ready are loaded in the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= ~map_ok | (pwrite & (ro_reg | ~pprot[0])); // [R09]
      prdata <= pwrite ? 32'h00000000 : rd_mux;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
  end

  // ========================================================
  // Control registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      action <= `SAC_ACTION_RST;
      ien <= `SAC_IEN_RST;
    end else if (wr_en) begin
      if (paddr == `SAC_OFF_ACTION) begin
        action <= pwdata[3:0];
      end
      if (paddr == `SAC_OFF_IEN) begin
        ien <= pwdata[`SAC_NINT-1:0];
      end
    end
  end

  // ========================================================
  // Lifecycle: loaded from the set-only flag after reset, and
  // only ever moves from test to application
  reg [2:0] lc_wait;
  wire key_wr;

  assign key_wr = wr_en & (paddr == `SAC_OFF_LCYC) &
                  (pwdata == `SAC_LC_KEY);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lc_state <= LC_INIT;
      lc_wait <= 3'h0;
      nv_app_prog <= 1'b0;
    end else begin
      nv_app_prog <= 1'b0;
      case (lc_state)
        LC_INIT: begin
          // Strap reaches pin_f only after the fourth edge; read it later
          if (lc_wait == 3'h4) begin
            lc_state <= pin_f[12] ? LC_APP : LC_TEST; // [R11]
          end else begin
            lc_wait <= lc_wait + 3'h1;
          end
        end
        LC_TEST: begin
          if (key_wr) begin
            lc_state <= LC_APP; // [R06]
            nv_app_prog <= 1'b1; // [R11]
          end
        end
        LC_APP: begin
          lc_state <= LC_APP; // [R06]
        end
        default: begin
          // Corrupted state falls to the safe side
          lc_state <= LC_APP; // [R06]
        end
      endcase
    end
  end

  // Test functions only while the lifecycle reads test mode
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      test_mode_en <= 1'b0;
      func_test_en <= 1'b0;
    end else begin
      test_mode_en <= pin_f[10] & (lc_state == LC_TEST); // [R06]
      func_test_en <= pin_f[11] & (lc_state == LC_TEST); // [R08]
    end
  end

  // ========================================================
  // Access policy; INIT counts as application mode, so nothing
  // slips through before the strap is known
  wire app_eff;
  wire in_mfg;
  wire in_sfr;
  wire in_tst;
  wire deny;

  assign app_eff = ~lc_state[1];
  assign in_mfg = (acc_addr >= `SAC_MFG_LO) && (acc_addr <= `SAC_MFG_HI);
  assign in_sfr = (acc_addr >= `SAC_SFR_LO) && (acc_addr <= `SAC_SFR_HI);
  assign in_tst = (acc_addr >= `SAC_TST_LO) && (acc_addr <= `SAC_TST_HI);
  assign deny = (in_mfg & acc_wr & app_eff) | // [R07]
                (in_sfr & ~acc_priv) | // [R09]
                (in_tst & ~test_mode_en); // [R08]

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_grant <= 1'b0;
      acc_deny <= 1'b0;
      hardfault <= 1'b0;
      fault_addr <= 32'h00000000;
    end else begin
      acc_grant <= acc_req & ~deny;
      acc_deny <= acc_req & deny; // [R09]
      hardfault <= (acc_req & deny) | apb_viol; // [R09]
      if (acc_req & deny) begin
        fault_addr <= acc_addr;
      end
    end
  end

  // ========================================================
  // Interrupt status: new set wins over a clear in the same cycle
  wire [`SAC_NINT-1:0] int_set;
  wire [`SAC_NINT-1:0] int_clr;

  assign int_set = {(acc_req & deny) | apb_viol, ev};
  assign int_clr = (wr_en && paddr == `SAC_OFF_ICLR) ?
                   pwdata[`SAC_NINT-1:0] : 13'h0000;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ists <= 13'h0000;
      irq <= 1'b0;
    end else begin
      ists <= (ists & ~int_clr) | int_set; // [R01]
      irq <= |(ists & ien);
    end
  end

endmodule

// ===== sac_ctrl_properties.sv
// Concurrent checks on the alarm, lifecycle and access ports
`timescale 1ns/1ps
`include "sac_consts.vh"
module sac_ctrl_properties (
  input wire pclk,
  input wire presetn,
  input wire [4:0] env_alarm,
  input wire shield_alarm,
  input wire probe_alarm,
  input wire nv_app_flag,
  input wire test_mode_en,
  input wire func_test_en,
  input wire acc_req,
  input wire acc_wr,
  input wire acc_priv,
  input wire [31:0] acc_addr,
  input wire acc_grant,
  input wire acc_deny,
  input wire hardfault,
  input wire chip_rst_req,
  input wire irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Region decode, kept apart from the design's own decode
  wire mfg = acc_addr >= `SAC_MFG_LO && acc_addr <= `SAC_MFG_HI;
  wire sfr = acc_addr >= `SAC_SFR_LO && acc_addr <= `SAC_SFR_HI;

  // ==========================================================
  // Alarm response; pins need four sync edges first
  chk_env_reset: assert property ((|env_alarm)[*4] |-> ##[0:3] chip_rst_req)
    else $error("environment alarm gave no chip reset");
  chk_tamper_reset: assert property
    ((shield_alarm || probe_alarm)[*4] |-> ##[0:3] chip_rst_req)
    else $error("tamper alarm gave no chip reset");
  chk_rst_held: assert property ($rose(chip_rst_req) |=> chip_rst_req[*8])
    else $error("chip reset request too short");

  // ==========================================================
  // Lifecycle locks
  chk_app_no_test: assert property (nv_app_flag[*6] |-> !test_mode_en)
    else $error("test mode enabled in application mode");
  chk_func_locked: assert property (nv_app_flag[*6] |-> !func_test_en)
    else $error("functional test enabled outside test mode");

  // ==========================================================
  // Access policy answers
  chk_acc_answer: assert property (acc_req |=> acc_grant != acc_deny)
    else $error("access not answered by exactly one of grant or deny");
  chk_idle_quiet: assert property (!acc_req |=> !acc_grant && !acc_deny)
    else $error("access answer without request");
  chk_deny_fault: assert property (acc_deny |-> hardfault)
    else $error("denied access without hard fault");
  chk_sfr_unpriv: assert property (acc_req && sfr && !acc_priv |=> acc_deny)
    else $error("unprivileged register access not denied");
  chk_mfg_read: assert property (acc_req && mfg && !acc_wr |=> acc_grant)
    else $error("manufacturing area read refused");
  chk_mfg_lock: assert property
    (acc_req && mfg && acc_wr && nv_app_flag |=> acc_deny)
    else $error("manufacturing area write in application mode");

  // Main scenarios reached
  cover property (acc_deny);
  cover property ($rose(chip_rst_req));
  cover property (irq);
endmodule

bind sac_ctrl sac_ctrl_properties u_chk (.pclk, .presetn, .env_alarm,
  .shield_alarm, .probe_alarm, .nv_app_flag, .test_mode_en, .func_test_en,
  .acc_req, .acc_wr, .acc_priv, .acc_addr, .acc_grant, .acc_deny,
  .hardfault, .chip_rst_req, .irq);

// ===== sac_cpu_model.sv
// Processor model issuing single-cycle memory and register accesses
`timescale 1ns/1ps
module sac_cpu_model (
  input wire pclk,
  output logic acc_req,
  output logic acc_wr,
  output logic acc_priv,
  output logic [31:0] acc_addr,
  input wire acc_grant,
  input wire acc_deny
);
  initial begin
    acc_req = 1'h0;
    acc_wr = 1'h0;
    acc_priv = 1'h0;
    acc_addr = 32'h0;
  end

  // One request cycle; write flag and address scrambled after it so no stale match
  task automatic access(input logic w, p, input logic [31:0] a,
                        output logic gg, dd);
    @(posedge pclk);
    acc_req <= 1'h1;
    acc_wr <= w;
    acc_priv <= p;
    acc_addr <= a;
    @(posedge pclk);
    acc_req <= 1'h0;
    acc_wr <= ~w;
    acc_addr <= ~a;
    @(posedge pclk);
    gg = acc_grant;
    dd = acc_deny;
  endtask
endmodule

// ===== security_alarm_lifecycle_ctrl_tb.sv
// Self-checking testbench for the security alarm controller
`timescale 1ns/1ps
`include "sac_consts.vh"
module security_alarm_lifecycle_ctrl_tb;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d;
    logic [31:0] x; logic e;} sac_row_t;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd, acc_addr;
  logic [2:0] pprot = 3'h1;
  logic [4:0] env_alarm = 0;
  logic selftest_fail = 0, rng_total_fail = 0, rng_stat_fail = 0;
  logic shield_alarm = 0, probe_alarm = 0, ext_clk_pad = 0, ext_rst_pad = 0;
  logic nv_app_flag = 0, test_req = 0, func_test_req = 0, clk_run = 1;
  logic pready, pslverr, er, g, d, c1, ext_clk_clean, ext_rst_clean;
  logic nv_app_prog, test_mode_en, func_test_en, acc_req, acc_wr, acc_priv;
  logic acc_grant, acc_deny, chip_rst_req, alarm_exc, hardfault, irq;
  int n_fail = 0, cmp_count = 0, n_hf = 0, n_exc = 0, h;
  sac_row_t rows [15];

  sac_ctrl uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pprot, .prdata, .pready, .pslverr, .env_alarm, .selftest_fail,
    .rng_total_fail, .rng_stat_fail, .shield_alarm, .probe_alarm,
    .ext_clk_pad, .ext_rst_pad, .ext_clk_clean, .ext_rst_clean,
    .nv_app_flag, .nv_app_prog, .test_req, .func_test_req, .test_mode_en,
    .func_test_en, .acc_req, .acc_wr, .acc_priv, .acc_addr, .acc_grant,
    .acc_deny, .chip_rst_req, .alarm_exc, .hardfault, .irq);
  sac_cpu_model cpu (.pclk, .acc_req, .acc_wr, .acc_priv, .acc_addr,
    .acc_grant, .acc_deny);

  // ==========================================================
  // Clock, pad clock at half period of 5 cycles, pulse counters
  always #5 pclk = ~pclk;
  always begin
    repeat (5) @(posedge pclk);
    if (clk_run) ext_clk_pad <= ~ext_clk_pad;
  end
  always @(posedge pclk) begin
    if (presetn) n_hf <= n_hf + hardfault;
    if (presetn) n_exc <= n_exc + alarm_exc;
    if (nv_app_prog) nv_app_flag <= 1'h1;
  end

  task automatic chk(input string nm, input logic [31:0] x, y);
    cmp_count++;
    if (y !== x) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, x, y);
    end
  endtask

  // APB transfer; entered just after an edge, leaves one idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dt);
    int n;
    n = 0;
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dt;
    @(posedge pclk) penable <= 1;
    do @(posedge pclk); while (pready !== 1'h1 && ++n < 20);
    if (n >= 20) begin
      n_fail++;
      $display("Error pready expected 1 seen %h", pready);
    end
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask

  task automatic por;
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    repeat (8) @(posedge pclk);
  endtask

  task automatic final_report;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog far above the expected run of about 1900 cycles
  initial begin
    #200000;
    n_fail++;
    final_report;
  end

  // ==========================================================
  // Main sequence
  initial begin
    rows = '{{1'h0,8'h00,32'h0,32'h0,1'h0}, {1'h0,8'h04,32'h0,32'h0,1'h0},
      {1'h0,8'h0c,32'h0,32'h0,1'h0}, {1'h0,8'h10,32'h0,32'h7,1'h0},
      {1'h0,8'h14,32'h0,32'h1,1'h0}, {1'h1,8'h0c,32'h1fff,32'h0,1'h0},
      {1'h0,8'h0c,32'h0,32'h1fff,1'h0}, {1'h1,8'h00,32'h1,32'h0,1'h1},
      {1'h1,8'h04,32'h1,32'h0,1'h1}, {1'h1,8'h18,32'h1,32'h0,1'h1},
      {1'h0,8'h1c,32'h0,32'h0,1'h1}, {1'h0,8'h02,32'h0,32'h0,1'h1},
      {1'h1,8'h14,32'h12345678,32'h0,1'h0}, {1'h0,8'h14,32'h0,32'h1,1'h0},
      {1'h1,8'h0c,32'h1000,32'h0,1'h0}};
    repeat (6) @(posedge pclk);
    presetn <= 1;
    repeat (8) @(posedge pclk);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk("pslverr", 32'(rows[i].e), 32'(er));
      if (!rows[i].w && !rows[i].e) chk("prdata", rows[i].x, rd);
    end
    // Test state: test functions and manufacturing writes allowed
    test_req <= 1;
    func_test_req <= 1;
    repeat (6) @(posedge pclk);
    chk("test_en", 32'h3, 32'({test_mode_en, func_test_en}));
    cpu.access(1, 1, 32'h00080010, g, d);
    chk("mfg_wr_test", 32'h2, 32'({g, d}));
    cpu.access(0, 0, 32'h50000000, g, d);
    chk("tst_rd_test", 32'h2, 32'({g, d}));
    // Unprivileged write refused, fault raised, interrupt set and cleared
    h = n_hf;
    pprot <= 3'h0;
    apb(1, 8'h0c, 32'h0);
    pprot <= 3'h1;
    chk("unpriv_err", 32'h1, 32'(er));
    repeat (2) @(posedge pclk);
    chk("unpriv_hf", 32'h1, n_hf - h);
    chk("irq_set", 32'h1, 32'(irq));
    apb(0, 8'h0c, 32'h0);
    chk("ien_kept", 32'h1000, rd);
    apb(1, 8'h08, 32'h1000);
    repeat (2) @(posedge pclk);
    chk("irq_clr", 32'h0, 32'(irq));
    cpu.access(0, 0, 32'h40000123, g, d);
    chk("sfr_unpriv", 32'h1, 32'({g, d}));
    apb(0, 8'h18, 32'h0);
    chk("fault_addr", 32'h40000123, rd);
    // Switch to application mode, then survive a power-on reset
    apb(1, 8'h14, `SAC_LC_KEY);
    repeat (4) @(posedge pclk);
    chk("nv_flag", 32'h1, 32'(nv_app_flag));
    por;
    apb(1, 8'h14, 32'h0);
    apb(0, 8'h14, 32'h0);
    chk("lcyc_app", 32'h3, rd);
    chk("test_off", 32'h0, 32'({test_mode_en, func_test_en}));
    cpu.access(1, 1, 32'h00080010, g, d);
    chk("mfg_wr_app", 32'h1, 32'({g, d}));
    cpu.access(0, 1, 32'h00080010, g, d);
    chk("mfg_rd_app", 32'h2, 32'({g, d}));
    cpu.access(0, 1, 32'h50000000, g, d);
    chk("tst_app", 32'h1, 32'({g, d}));
    // Each of the ten pin alarm sources; self-test and generator set to exception class
    apb(1, 8'h10, 32'h0);
    for (int i = 0; i < 10; i++) begin
      h = n_exc;
      {probe_alarm, shield_alarm, rng_stat_fail, rng_total_fail,
        selftest_fail, env_alarm} <= 10'h1 << i;
      repeat (6) @(posedge pclk);
      chk("rst_req", 32'(i < 5 || i > 7), 32'(chip_rst_req));
      {probe_alarm, shield_alarm, rng_stat_fail, rng_total_fail,
        selftest_fail, env_alarm} <= 10'h0;
      repeat (120) @(posedge pclk);
      chk("exc", 32'(i > 4 && i < 8), n_exc - h);
      chk("rst_end", 32'h0, 32'(chip_rst_req));
      apb(0, 8'h00, 32'h0);
      chk("cause", (32'h2 << i) - 1, rd);
    end
    // Reset pad: long level passes, short pulse is an alarm
    ext_rst_pad <= 1;
    repeat (30) @(posedge pclk);
    chk("rst_clean", 32'h1, 32'(ext_rst_clean));
    ext_rst_pad <= 0;
    repeat (4) @(posedge pclk);
    ext_rst_pad <= 1;
    repeat (130) @(posedge pclk);
    apb(0, 8'h00, 32'h0);
    chk("cause_rpad", 32'hbff, rd);
    // Clock pad: running pad passes filtered, stopped pad is an alarm
    apb(1, 8'h10, 32'h8);
    c1 = ext_clk_clean;
    repeat (5) @(posedge pclk);
    chk("clk_clean", 32'h1, 32'(c1 ^ ext_clk_clean));
    apb(0, 8'h00, 32'h0);
    chk("cause_cpad", 32'hbff, rd);
    clk_run = 0;
    repeat (250) @(posedge pclk);
    apb(0, 8'h00, 32'h0);
    chk("cause_stop", 32'hfff, rd);
    // Only power-on reset clears the cause record
    por;
    apb(0, 8'h00, 32'h0);
    chk("cause_por", 32'h0, rd);
    final_report;
  end
endmodule
